// File: verilog/ddac_pkg.sv
// Package for the dual DAC serial load logic: frame layout, widths, reset values.
// Assumes a single 100 MHz system clock that samples the serial link pins.
package ddac_pkg;
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
    localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
    localparam int BIT_CHAN = 15;
    localparam int BIT_BUF = 14;
    localparam int BIT_PD_HI = 13;
    localparam int BIT_PD_LO = 12;
    localparam int DATA_MSB = 11;
    localparam int DATA_W = 12;
    localparam logic [DATA_W-1:0] DATA_RESET = 12'h000;
    localparam logic [1:0] PD_RESET = 2'h0;
    localparam logic BUF_RESET = 1'b0;
    localparam int NUM_CHAN = 2;
    // Link limit, for reference by the bench
    localparam int LINK_MAX_MHZ = 30;
    // Pin reset levels, in order sync, clock, data, load; sync, data and load reset high
    localparam int PIN_COUNT = 4;
    localparam logic [PIN_COUNT-1:0] PIN_INIT = 4'hB;

    typedef struct packed {
        logic buf_sel;
        logic pwrdn_mode_hi;
        logic pwrdn_mode_lo;
        logic [DATA_W-1:0] code;
    } ddac_chan_type;

    localparam ddac_chan_type CHAN_RESET = '{BUF_RESET, 1'b0, 1'b0, DATA_RESET};

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SHIFT = 2'h1,
        ST_DONE = 2'h3
    } ddac_state_type;
endpackage

// File: verilog/ddac_sync2.sv
// Two flip-flop synchroniser for a bundle of pin inputs.
// Assumes pins are asynchronous to clk_i; reset value given as a parameter.
`timescale 1ns/10ps
module ddac_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    always_comb begin
        next_meta = srst_i ? INIT : d_i;
        next_q = srst_i ? INIT : meta;
    end

    always_ff @(posedge clk_i) begin
        meta <= next_meta;
        q_o <= next_q;
    end
endmodule // ddac_sync2

// File: verilog/ddac_core.sv
// Serial front end of a dual DAC: frame shift, input and DAC registers, load strobe.
// Assumes link pins are asynchronous and slower than a quarter of ref_clk_i.
`timescale 1ns/10ps
// Behaviour
// - Load strobe low copies each input register into its DAC register.
// - One strobe pulse updates both DAC registers together.
// - Sync falling edge enables clock and data capture, arms shift register.
// - Sample data on each of the next sixteen serial clock falling edges.
// - Sync rising before sixteenth falling edge discards the partial frame.
// - Sixteen-bit input shift register captures on serial clock falling edges.
// - Serial clock capture disabled after each write until next sync fall.
// - Serial data capture disabled after each write until next sync fall.
// - Each channel keeps its own reference buffer select from its frame.
// - First bit is bit 15, selecting channel A (0) or B (1).
// - Frame holds four control bits then up to twelve data bits.
// - Reset clears input and DAC registers, unbuffered, normal operation.
module ddac_core
    import ddac_pkg::*;
#(
    parameter int RES_BITS = 12
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic sync_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    input wire logic load_outputs_n_i,
    output ddac_pkg::ddac_chan_type dac_a_o,
    output ddac_pkg::ddac_chan_type dac_b_o,
    output ddac_pkg::ddac_chan_type input_a_o,
    output ddac_pkg::ddac_chan_type input_b_o,
    output logic link_active_o,
    output logic frame_abort_o
);
    import ddac_pkg::*;

    // Elaboration checks: refuse settings the frame layout cannot carry
    if (RES_BITS != 8 && RES_BITS != 10 && RES_BITS != 12) begin : g_bad_res
        $error("RES_BITS must be 8, 10 or 12");
    end
    if (RES_BITS > DATA_W) begin : g_bad_width
        $error("RES_BITS wider than the code field");
    end
    if (RES_BITS > DATA_MSB + 1) begin : g_bad_fit
        $error("RES_BITS does not fit below the control bits");
    end
    if ((1 << CNT_W) <= FRAME_BITS) begin : g_bad_cnt
        $error("Bit counter too narrow for a whole frame");
    end
    if (int'(CNT_FULL) != FRAME_BITS) begin : g_bad_full
        $error("Full count differs from the frame length");
    end
    if (NUM_CHAN != 2) begin : g_bad_chan
        $error("Only two channel port pairs are wired");
    end

    logic [PIN_COUNT-1:0] pins_s;
    logic sync_n_s;
    logic sclk_s;
    logic din_s;
    logic load_n_s;
    logic sclk_d;
    logic sync_d;

    // Pins cross into ref_clk_i before any logic reads them
    ddac_sync2 #(
        .WIDTH(PIN_COUNT),
        .INIT(PIN_INIT)
    ) u_sync (
        .clk_i(ref_clk_i),
        .srst_i(srst_i),
        .d_i({sync_n_i, sclk_i, din_i, load_outputs_n_i}),
        .q_o(pins_s)
    );

    assign sync_n_s = pins_s[3];
    assign sclk_s = pins_s[2];
    assign din_s = pins_s[1];
    assign load_n_s = pins_s[0];

    ddac_state_type state;
    ddac_state_type next_state;
    logic [FRAME_BITS-1:0] shreg;
    logic [FRAME_BITS-1:0] next_shreg;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic next_sclk_d;
    logic next_sync_d;
    logic next_active;
    logic next_abort;
    logic commit;
    logic sclk_fall;
    logic sync_fall;
    logic sync_rise;
    ddac_chan_type frame_chan;
    ddac_chan_type in_reg [NUM_CHAN];
    ddac_chan_type next_in_reg [NUM_CHAN];
    ddac_chan_type dac_reg [NUM_CHAN];
    ddac_chan_type next_dac_reg [NUM_CHAN];

    // Edge detect on synchronised copies only; the first flop is never read
    // Pin to register update costs two to three clocks through the synchroniser
    assign sclk_fall = sclk_d & ~sclk_s;
    assign sync_fall = sync_d & ~sync_n_s;
    assign sync_rise = ~sync_d & sync_n_s;

    // Frame decode; data sits left aligned below the control bits
    always_comb begin
        frame_chan.buf_sel = shreg[BIT_BUF];
        frame_chan.pwrdn_mode_hi = shreg[BIT_PD_HI];
        frame_chan.pwrdn_mode_lo = shreg[BIT_PD_LO];
        frame_chan.code = DATA_RESET;
        frame_chan.code[RES_BITS-1:0] = shreg[DATA_MSB -: RES_BITS];
    end

    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_cnt = cnt;
        next_sclk_d = sclk_s;
        next_sync_d = sync_n_s;
        next_abort = 1'b0;
        commit = 1'b0;
        case (state)
            ST_IDLE: begin
                // Clock and data are ignored here, standing in for powered-down buffers
                if (sync_fall) begin
                    next_state = ST_SHIFT;
                    next_cnt = CNT_ZERO;
                    next_shreg = '0;
                end
            end
            ST_SHIFT: begin
                if (sync_rise) begin
                    next_state = ST_IDLE;
                    next_abort = 1'b1;
                end else if (sclk_fall) begin
                    next_shreg = {shreg[FRAME_BITS-2:0], din_s};
                    next_cnt = cnt + 5'h01;
                    if (cnt == CNT_FULL - 5'h01)
                        next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                // Extra edges are ignored until sync rises
                if (sync_rise) begin
                    next_state = ST_IDLE;
                    commit = 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        next_active = (next_state != ST_IDLE);
        if (srst_i) begin
            next_state = ST_IDLE;
            next_shreg = '0;
            next_cnt = CNT_ZERO;
            next_sclk_d = 1'b0;
            next_sync_d = 1'b1;
            next_active = 1'b0;
            next_abort = 1'b0;
        end
    end

    // State register only; every next value comes from the process above
    always_ff @(posedge ref_clk_i) begin
        state <= next_state;
        shreg <= next_shreg;
        cnt <= next_cnt;
        sclk_d <= next_sclk_d;
        sync_d <= next_sync_d;
        link_active_o <= next_active;
        frame_abort_o <= next_abort;
    end

    // Per channel input and DAC registers
    generate
        for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
            logic hit;
            assign hit = commit && (shreg[BIT_CHAN] == 1'(ch));
            always_comb begin
                next_in_reg[ch] = in_reg[ch];
                next_dac_reg[ch] = dac_reg[ch];
                if (hit)
                    next_in_reg[ch] = frame_chan;
                // Level sensitive: strobe held low makes new input data transparent
                if (!load_n_s)
                    next_dac_reg[ch] = next_in_reg[ch];
                // Reset last, so it wins over a commit or load in the same cycle
                if (srst_i) begin
                    next_in_reg[ch] = CHAN_RESET;
                    next_dac_reg[ch] = CHAN_RESET;
                end
            end
            always_ff @(posedge ref_clk_i) begin
                in_reg[ch] <= next_in_reg[ch];
                dac_reg[ch] <= next_dac_reg[ch];
            end
        end
    endgenerate

    // Ports mirror the registers one for one, straight from flops
    ddac_chan_type next_out [4];
    always_comb begin
        next_out[0] = next_dac_reg[0];
        next_out[1] = next_dac_reg[1];
        next_out[2] = next_in_reg[0];
        next_out[3] = next_in_reg[1];
    end

    always_ff @(posedge ref_clk_i) begin
        dac_a_o <= next_out[0];
        dac_b_o <= next_out[1];
        input_a_o <= next_out[2];
        input_b_o <= next_out[3];
    end
endmodule // ddac_core

// File: testbench/ddac_checker.sv
// Port-level assertions for the dual DAC serial load logic.
// Assumes the design's ports only; bound to every ddac_core instance.
`timescale 1ns/10ps
module ddac_checker
    import ddac_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic sync_n_i,
    input wire logic sclk_i,
    input wire logic din_i,
    input wire logic load_outputs_n_i,
    input ddac_pkg::ddac_chan_type dac_a_o,
    input ddac_pkg::ddac_chan_type dac_b_o,
    input ddac_pkg::ddac_chan_type input_a_o,
    input ddac_pkg::ddac_chan_type input_b_o,
    input wire logic link_active_o,
    input wire logic frame_abort_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    reset_clear_a: assert property ($fell(srst_i) |-> {dac_a_o, dac_b_o, input_a_o, input_b_o} == '0)
        else $error("outputs not cleared after reset");
    dac_hold_a: assert property (load_outputs_n_i [*5] |-> $stable(dac_a_o) && $stable(dac_b_o))
        else $error("DAC register moved with strobe high");
    load_copy_a: assert property ((!load_outputs_n_i) [*5] |-> dac_a_o == input_a_o && dac_b_o == input_b_o)
        else $error("DAC register differs from input register under strobe");
    input_hold_a: assert property (sync_n_i [*6] |-> $stable(input_a_o) && $stable(input_b_o))
        else $error("input register moved with sync idle");
    link_idle_a: assert property (sync_n_i [*5] |-> !link_active_o)
        else $error("link armed with sync idle");
    arm_frame_a: assert property ($fell(sync_n_i) ##0 (!sync_n_i) [*6] |-> link_active_o)
        else $error("sync fall did not arm the link");
    abort_pulse_a: assert property (frame_abort_o |-> $stable(input_a_o) && $stable(input_b_o) ##1 !frame_abort_o)
        else $error("abort changed registers or lasted too long");
    abort_cause_a: assert property ($rose(frame_abort_o) |-> $past(sync_n_i) && !$past(sync_n_i, 8))
        else $error("abort without a sync rise");
    one_chan_a: assert property (!$stable(input_a_o) |-> $stable(input_b_o))
        else $error("one frame changed both channels");
    cover property (frame_abort_o);
    cover property (!$stable(input_b_o));
    cover property (!load_outputs_n_i && !$stable(dac_a_o));
endmodule // ddac_checker
bind ddac_core ddac_checker chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .sync_n_i(sync_n_i),
    .sclk_i(sclk_i), .din_i(din_i), .load_outputs_n_i(load_outputs_n_i), .dac_a_o(dac_a_o),
    .dac_b_o(dac_b_o), .input_a_o(input_a_o), .input_b_o(input_b_o),
    .link_active_o(link_active_o), .frame_abort_o(frame_abort_o));

// File: testbench/ddac_host.sv
// Host serial port model: sync, falling-edge clock, MSB-first data.
// Assumes the bench calls xfer; clock idles high and toggles between frames only in idle_clocks.
`timescale 1ns/10ps
module ddac_host (
    output logic sync_n_o,
    output logic sclk_o,
    output logic din_o
);
    initial begin
        sync_n_o = 1'b1;
        sclk_o = 1'b1;
        din_o = 1'b0;
    end
    // Fewer than 16 falls only when the bench asks for an abort
    // Non-blocking, so a change landing on a system clock edge does not race
    task automatic xfer(input logic [15:0] w, input int n);
        sync_n_o <= 1'b0;
        for (int i = 0; i < n; i++) begin
            din_o <= (i < 16) ? w[15 - i] : ~din_o;
            #62.5 sclk_o <= 1'b0;
            #62.5 sclk_o <= 1'b1;
        end
        #20 sync_n_o <= 1'b1;
        din_o <= ~din_o;
        #200;
    endtask
    // Clock and data toggling with sync high must leave the block untouched
    task automatic idle_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            din_o <= ~din_o;
            #62.5 sclk_o <= 1'b0;
            #62.5 sclk_o <= 1'b1;
        end
        #200;
    endtask
endmodule // ddac_host

// File: testbench/tb.sv
// Self-checking bench: random frames, aborts, strobe pulse and held strobe.
// Assumes ddac_core with default resolution and the host model.
`timescale 1ns/10ps
module tb;
    import ddac_pkg::*;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic load_outputs_n_i = 1'b1;
    logic sync_n, sclk, din, act, abrt;
    ddac_chan_type in_a, in_b, dac_a, dac_b, ea, eb, xa, xb;
    logic [59:0] last, prev;
    logic [60:0] notes[$];
    int checks = 0;
    int bad_count = 0;
    int cyc = 0;
    ddac_host host (.sync_n_o(sync_n), .sclk_o(sclk), .din_o(din));
    ddac_core dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .sync_n_i(sync_n), .sclk_i(sclk),
        .din_i(din), .load_outputs_n_i(load_outputs_n_i), .dac_a_o(dac_a), .dac_b_o(dac_b),
        .input_a_o(in_a), .input_b_o(in_b), .link_active_o(act), .frame_abort_o(abrt));
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic note(input logic ab);
        if (ab || {ea, eb, xa, xb} != last) begin
            notes.push_back({ab, ea, eb, xa, xb});
            last = {ea, eb, xa, xb};
        end
    endtask
    task automatic frame(input int n, input logic ld_low);
        logic [15:0] w;
        w = 16'($urandom);
        if (n >= 16 && w[15]) eb = w[14:0];
        if (n >= 16 && !w[15]) ea = w[14:0];
        if (ld_low) begin
            xa = ea;
            xb = eb;
        end
        note(n < 16);
        host.xfer(w, n);
        repeat (8) @(posedge ref_clk_i);
    endtask
    // Result watcher; negedge so the design's updates have landed
    always @(negedge ref_clk_i) begin
        if (!srst_i && (abrt || {in_a, in_b, dac_a, dac_b} !== prev)) begin
            checks++;
            if (notes.size() == 0 || notes[0] !== {abrt, in_a, in_b, dac_a, dac_b}) begin
                bad_count++;
                $display("[ERR] %0t unexpected output change", $time);
            end
            if (notes.size() != 0) void'(notes.pop_front());
        end
        prev = {in_a, in_b, dac_a, dac_b};
    end
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            $display("[ERR] %0t timeout", $time);
            give_verdict();
        end
    end
    initial begin
        void'($urandom(32'hAED2D97C));
        {ea, eb, xa, xb, last} = '0;
        repeat (12) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        @(negedge ref_clk_i);
        checks++;
        if ({in_a, in_b, dac_a, dac_b, act, abrt} !== '0) begin
            bad_count++;
            $display("[ERR] %0t reset state wrong", $time);
        end
        for (int i = 0; i < 6; i++) frame(16 + i % 3, 1'b0);
        xa = ea;
        xb = eb;
        note(1'b0);
        @(posedge ref_clk_i) load_outputs_n_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        load_outputs_n_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        host.idle_clocks(16);
        for (int i = 0; i < 4; i++) frame($urandom_range(15, 1), 1'b0);
        @(posedge ref_clk_i) load_outputs_n_i <= 1'b0;
        for (int i = 0; i < 4; i++) frame(16, 1'b1);
        repeat (10) @(posedge ref_clk_i);
        if (notes.size() != 0) begin
            bad_count++;
            $display("[ERR] %0t expected change missing", $time);
        end
        give_verdict();
    end
endmodule // tb
